// ==== wcd_cfg.svh ====
`ifndef WCD_CFG_SVH
`define WCD_CFG_SVH

// ----------------------------------------------------------------
// instruction encodings
// ----------------------------------------------------------------
`define WCD_WDT_CLEAR_WORD 14'h0064
`define WCD_DEC_OPC        6'h03
`define WCD_INV_OPC        6'h09
`define WCD_OPC_MSB        13
`define WCD_OPC_LSB        8
`define WCD_DEST_BIT       7

// ----------------------------------------------------------------
// register port offsets (byte addresses)
// ----------------------------------------------------------------
`define WCD_CTRL_OFS       12'h000
`define WCD_WREG_OFS       12'h004
`define WCD_STAT_OFS       12'h008
`define WCD_FILE_BASE      12'h200
`define WCD_FILE_MASK      12'hE00

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define WCD_CTRL_EN_BIT    0
`define WCD_STAT_TO_BIT    0
`define WCD_STAT_PD_BIT    1
`define WCD_STAT_Z_BIT     2
`define WCD_STAT_UNS_BIT   3
`define WCD_CTRL_RST       1'h1
`define WCD_FLAG_N_RST     1'h1
`define WCD_WREG_RST       8'h00
`define WCD_WDT_ZERO       8'h00

`endif

// ==== wcd_exec.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "wcd_cfg.svh"

module wcd_exec
	import wcd_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// instruction from decoder
	input  wire logic        instr_valid,
	input  wire logic [13:0] instr_word,
	// events from watchdog and sleep logic
	input  wire logic        wdt_timeout_evt,
	input  wire logic        sleep_evt,
	// register port
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// watchdog controls
	output logic             wdt_count_clear,
	output logic             wdt_presc_clear,
	// status flags and results
	output logic             timeout_flag_n,
	output logic             powerdown_flag_n,
	output logic             zero_flag,
	output logic       [7:0] w_reg,
	output logic             exec_done
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------

	// classify an instruction word
	function automatic wcd_op_t decode_op(input logic [13:0] iw);
		wcd_op_t op;
		op = WCD_OP_NONE;
		if (iw == `WCD_WDT_CLEAR_WORD) begin
			op = WCD_OP_WDT;
		end else if (iw[`WCD_OPC_MSB:`WCD_OPC_LSB] == `WCD_DEC_OPC) begin
			op = WCD_OP_DEC;
		end else if (iw[`WCD_OPC_MSB:`WCD_OPC_LSB] == `WCD_INV_OPC) begin
			op = WCD_OP_INV;
		end
		return op;
	endfunction : decode_op

	// register port address falls into the file register window
	function automatic logic in_file_win(input logic [11:0] a);
		return (a & `WCD_FILE_MASK) == `WCD_FILE_BASE;
	endfunction : in_file_win

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	wcd_op_t   op_d;         // op of the incoming word
	logic      en_q;         // execution enable from control register
	wcd_op_t   ex_op_q;      // op in the execute stage
	logic      ex_dest_q;    // destination bit in the execute stage
	wcd_addr_t ex_addr_q;    // file address in the execute stage
	logic      fwd_q;        // execute operand comes from the last result
	wcd_data_t fwd_data_q;   // last written-back result
	wcd_data_t a_data;       // file operand from memory
	wcd_data_t b_data;       // file data for a register port read
	wcd_data_t opnd;         // operand after forwarding
	wcd_data_t result_d;     // result of the execute stage
	logic      ex_arith;     // execute stage holds a file op
	logic      file_wr;      // write-back to file this cycle
	logic      bus_fwr;      // register port file write
	logic      uns_q;        // last accepted word was not ours
	logic      rd_file_q;    // pending register port read of file
	logic      ctrl_hit_q;   // pending read of a port register
	logic [31:0] rd_reg_q;   // captured port register value

	assign op_d = decode_op(instr_word);

	// ----------------------------------------------------------------
	// execute stage datapath
	// ----------------------------------------------------------------

	// previous write-back to the same address overrides stale memory
	assign opnd = fwd_q ? fwd_data_q : a_data;

	// compute the result for the operation in the execute stage
	always_comb begin
		result_d = opnd;
		case (ex_op_q)
			WCD_OP_INV: begin
				result_d = ~opnd;
			end
			WCD_OP_DEC: begin
				result_d = opnd - 8'h01;
			end
			default: begin
				result_d = opnd;
			end
		endcase
	end

	assign ex_arith = (ex_op_q == WCD_OP_INV) || (ex_op_q == WCD_OP_DEC);
	// dest 1 writes the file register back
	assign file_wr  = ex_arith && ex_dest_q;
	// port writes to the file yield to a write-back
	assign bus_fwr  = reg_wr && in_file_win(reg_addr) && !file_wr;

	// ----------------------------------------------------------------
	// file register memory
	// ----------------------------------------------------------------
	wcd_file_mem u_mem (
		.clk_sys (clk_sys),
		.a_addr  (instr_word[6:0]),
		.a_data  (a_data),
		.b_addr  (reg_addr[8:2]),
		.b_data  (b_data),
		.wr_en   (file_wr || bus_fwr),
		.wr_addr (file_wr ? ex_addr_q : reg_addr[8:2]),
		.wr_data (file_wr ? result_d : reg_wdata[7:0])
	);

	// ----------------------------------------------------------------
	// decode stage registers
	// ----------------------------------------------------------------

	// capture the accepted word for the execute stage
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ex_op_q   <= WCD_OP_NONE;
			ex_dest_q <= 1'b0;
			ex_addr_q <= 7'h00;
			uns_q     <= 1'b0;
		end else if (instr_valid && en_q) begin
			ex_op_q   <= op_d;
			ex_dest_q <= instr_word[`WCD_DEST_BIT];
			ex_addr_q <= instr_word[6:0];
			uns_q     <= (op_d == WCD_OP_NONE);
		end else begin
			ex_op_q   <= WCD_OP_NONE;
		end
	end

	// forward the write-back when the next word reads the same address
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			fwd_q      <= 1'b0;
			fwd_data_q <= 8'h00;
		end else begin
			fwd_q      <= file_wr && (instr_word[6:0] == ex_addr_q);
			fwd_data_q <= result_d;
		end
	end

	// ----------------------------------------------------------------
	// watchdog clear pulses
	// ----------------------------------------------------------------

	// one pulse, one cycle after the word is accepted
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wdt_count_clear <= 1'b0;
			wdt_presc_clear <= 1'b0;
		end else begin
			wdt_count_clear <= instr_valid && en_q && (op_d == WCD_OP_WDT);
			// prescaler cleared in the same step
			wdt_presc_clear <= instr_valid && en_q && (op_d == WCD_OP_WDT);
		end
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------

	// the clear op wins over a same-cycle timeout or sleep event
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			timeout_flag_n   <= `WCD_FLAG_N_RST;
			powerdown_flag_n <= `WCD_FLAG_N_RST;
		end else if (ex_op_q == WCD_OP_WDT) begin
			timeout_flag_n   <= 1'b1;
			powerdown_flag_n <= 1'b1;
		end else begin
			if (wdt_timeout_evt) begin
				timeout_flag_n <= 1'b0;
			end
			if (sleep_evt) begin
				powerdown_flag_n <= 1'b0;
			end
		end
	end

	// zero flag follows every file op result
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			zero_flag <= 1'b0;
		end else if (ex_arith) begin
			zero_flag <= (result_d == 8'h00);
		end
	end

	// ----------------------------------------------------------------
	// working register
	// ----------------------------------------------------------------

	// execute write wins over a port write in the same cycle
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			w_reg <= `WCD_WREG_RST;
		end else if (ex_arith && !ex_dest_q) begin
			// dest 0 goes to working register
			w_reg <= result_d;
		end else if (reg_wr && reg_addr == `WCD_WREG_OFS) begin
			w_reg <= reg_wdata[7:0];
		end
	end

	// completion pulse for every executed word of ours
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			exec_done <= 1'b0;
		end else begin
			exec_done <= (ex_op_q != WCD_OP_NONE);
		end
	end

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------

	// control register: execution enable
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			en_q <= `WCD_CTRL_RST;
		end else if (reg_wr && reg_addr == `WCD_CTRL_OFS) begin
			en_q <= reg_wdata[`WCD_CTRL_EN_BIT];
		end
	end

	// capture the read target in the strobe cycle
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rd_file_q  <= 1'b0;
			ctrl_hit_q <= 1'b0;
			rd_reg_q   <= 32'h0000_0000;
		end else begin
			rd_file_q  <= reg_rd && in_file_win(reg_addr);
			ctrl_hit_q <= reg_rd && !in_file_win(reg_addr);
			rd_reg_q   <= 32'h0000_0000;
			if (reg_addr == `WCD_CTRL_OFS) begin
				rd_reg_q[`WCD_CTRL_EN_BIT] <= en_q;
			end else if (reg_addr == `WCD_WREG_OFS) begin
				rd_reg_q[7:0] <= w_reg;
			end else if (reg_addr == `WCD_STAT_OFS) begin
				rd_reg_q[`WCD_STAT_TO_BIT]  <= timeout_flag_n;
				rd_reg_q[`WCD_STAT_PD_BIT]  <= powerdown_flag_n;
				rd_reg_q[`WCD_STAT_Z_BIT]   <= zero_flag;
				rd_reg_q[`WCD_STAT_UNS_BIT] <= uns_q;
			end
		end
	end

	// read data stand only in the cycle after the strobe
	always_comb begin
		reg_rdata = 32'h0000_0000;
		if (rd_file_q) begin
			reg_rdata = {24'h00_0000, b_data};
		end else if (ctrl_hit_q) begin
			reg_rdata = rd_reg_q;
		end
	end

endmodule : wcd_exec

`default_nettype wire

// ==== wcd_exec_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "wcd_cfg.svh"

module wcd_exec_chk (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        resetn,
	// instruction and register port
	input wire logic        instr_valid,
	input wire logic [13:0] instr_word,
	input wire logic [11:0] reg_addr,
	input wire logic        reg_wr,
	// watched outputs
	input wire logic        wdt_count_clear,
	input wire logic        wdt_presc_clear,
	input wire logic        timeout_flag_n,
	input wire logic        powerdown_flag_n,
	input wire logic        zero_flag,
	input wire logic [7:0]  w_reg,
	input wire logic        exec_done
);
	// ----------------------------------------------------------------
	// helper pipeline
	// ----------------------------------------------------------------
	logic [14:0] p1_q, p2_q;       // {valid, word} one and two edges old
	logic        ww_q, ww2_q;      // working register writes seen
	wire  logic  reg_op3;          // decrement or invert retiring

	// copy of each word and of W writes, for cause lookup
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			p1_q <= 15'h0000;
			p2_q <= 15'h0000;
			ww_q <= 1'b0;
			ww2_q <= 1'b0;
		end else begin
			p1_q <= {instr_valid, instr_word};
			p2_q <= p1_q;
			ww_q <= reg_wr && (reg_addr == `WCD_WREG_OFS);
			ww2_q <= ww_q;
		end
	end

	// results and done show one edge after the word is taken
	assign reg_op3 = p2_q[14] && (p2_q[13:8] == `WCD_DEC_OPC || p2_q[13:8] == `WCD_INV_OPC);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_CNT_CLR_CAUSE: assert property (wdt_count_clear |-> p1_q == {1'b1, `WCD_WDT_CLEAR_WORD})
		else $error("count clear without clear word");
	AST_PRESC_PAIRED: assert property ((wdt_presc_clear || wdt_count_clear) |-> (wdt_presc_clear && wdt_count_clear))
		else $error("prescaler clear not paired with count clear");
	AST_CLR_SETS_FLAGS: assert property (wdt_count_clear |=> exec_done && timeout_flag_n && powerdown_flag_n)
		else $error("flags not set after clear");
	AST_DONE_CAUSE: assert property (exec_done |-> reg_op3 || p2_q == {1'b1, `WCD_WDT_CLEAR_WORD})
		else $error("done without recognised word");
	AST_W_CHANGE: assert property (!$stable(w_reg) |-> ww_q || ww2_q || (exec_done && reg_op3 && !p2_q[7]))
		else $error("working register changed without cause");
	AST_ZERO_OF_W: assert property (exec_done && reg_op3 && !p2_q[7] |-> zero_flag == (w_reg == 8'h00))
		else $error("zero flag disagrees with result");
	AST_ZERO_ONLY_OP: assert property (!$stable(zero_flag) |-> exec_done && reg_op3)
		else $error("zero flag changed outside an operation");

	// main scenarios reached
	COV_CLEAR: cover property (wdt_count_clear);
	COV_TO_W: cover property (exec_done && reg_op3 && !p2_q[7]);
	COV_TO_FILE: cover property (exec_done && reg_op3 && p2_q[7]);

endmodule : wcd_exec_chk

`default_nettype wire

// ==== wcd_file_mem.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// file register memory: two registered read ports, one write port
// ----------------------------------------------------------------
module wcd_file_mem
	import wcd_pkg::*;
(
	// clock
	input  wire logic      clk_sys,
	// core read port
	input  wire wcd_addr_t a_addr,
	output var  wcd_data_t a_data,
	// register port read
	input  wire wcd_addr_t b_addr,
	output var  wcd_data_t b_data,
	// single write port
	input  wire logic      wr_en,
	input  wire wcd_addr_t wr_addr,
	input  wire wcd_data_t wr_data
);

	// storage, no reset: contents are undefined until written
	wcd_data_t mem [0:127];

	// write port
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// read ports return the old value on a same-cycle write
	always_ff @(posedge clk_sys) begin
		a_data <= mem[a_addr];
		b_data <= mem[b_addr];
	end

endmodule : wcd_file_mem

`default_nettype wire

// ==== wcd_pkg.sv ====
package wcd_pkg;

	// ----------------------------------------------------------------
	// decoded operation, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		WCD_OP_NONE = 4'b0001,
		WCD_OP_WDT  = 4'b0010,
		WCD_OP_DEC  = 4'b0100,
		WCD_OP_INV  = 4'b1000
	} wcd_op_t;

	// file register address and data
	typedef logic [6:0] wcd_addr_t;
	typedef logic [7:0] wcd_data_t;

endpackage : wcd_pkg

// ==== wcd_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "wcd_cfg.svh"

`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected %s exp %0h got %0h", n, e, g); end end

module tb;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clk_sys, resetn, instr_valid, wdt_timeout_evt, sleep_evt, reg_wr, reg_rd;
	logic [13:0] instr_word;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic        wdt_count_clear, wdt_presc_clear, timeout_flag_n, powerdown_flag_n;
	logic        zero_flag, exec_done;
	logic [7:0]  w_reg;
	int          error_cnt, comparisons;

	wcd_exec DUT (.clk_sys(clk_sys), .resetn(resetn), .instr_valid(instr_valid),
		.instr_word(instr_word), .wdt_timeout_evt(wdt_timeout_evt), .sleep_evt(sleep_evt),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .wdt_count_clear(wdt_count_clear),
		.wdt_presc_clear(wdt_presc_clear), .timeout_flag_n(timeout_flag_n),
		.powerdown_flag_n(powerdown_flag_n), .zero_flag(zero_flag), .w_reg(w_reg),
		.exec_done(exec_done));

	// 40 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= {24'h000000, d};
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		`CHK("read data", e, reg_rdata)
	endtask : rd

	// one word; clear pulses stand just after the taking edge, done one edge later
	task automatic ex(input logic [13:0] w, input logic c, input logic dn);
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr_word <= w;
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		#1;
		`CHK("count clear", c, wdt_count_clear)
		`CHK("presc clear", c, wdt_presc_clear)
		@(posedge clk_sys);
		#1;
		`CHK("exec done", dn, exec_done)
	endtask : ex

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	// hang guard, far beyond the fewer than 90 cycles needed
	initial begin
		repeat (3000) @(posedge clk_sys);
		error_cnt++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		{resetn, instr_valid, wdt_timeout_evt, sleep_evt, reg_wr, reg_rd} = 6'h00;
		instr_word = 14'h0000;
		reg_addr = 12'h000;
		reg_wdata = 32'h00000000;
		error_cnt = 0;
		comparisons = 0;
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(`WCD_STAT_OFS, 32'h00000003);
		`CHK("w reset", 8'h00, w_reg)
		// drop both flags, then the clear word raises them
		@(posedge clk_sys);
		wdt_timeout_evt <= 1'b1;
		sleep_evt <= 1'b1;
		@(posedge clk_sys);
		wdt_timeout_evt <= 1'b0;
		sleep_evt <= 1'b0;
		rd(`WCD_STAT_OFS, 32'h00000000);
		`CHK("timeout flag", 1'b0, timeout_flag_n)
		`CHK("powerdown flag", 1'b0, powerdown_flag_n)
		ex(14'h0064, 1'b1, 1'b1);
		rd(`WCD_STAT_OFS, 32'h00000003);
		`CHK("timeout flag", 1'b1, timeout_flag_n)
		`CHK("powerdown flag", 1'b1, powerdown_flag_n)
		$display("test clear done");
		// decrement to file, then to W with wrap
		wr(12'h214, 8'h01);
		ex(14'h0385, 1'b0, 1'b1);
		`CHK("zero", 1'b1, zero_flag)
		rd(12'h214, 32'h00000000);
		wr(12'h218, 8'h00);
		ex(14'h0306, 1'b0, 1'b1);
		`CHK("w dec", 8'hFF, w_reg)
		`CHK("zero", 1'b0, zero_flag)
		rd(12'h218, 32'h00000000);
		$display("test decrement done");
		// invert to W, then to the top file register
		wr(12'h214, 8'h13);
		ex(14'h0905, 1'b0, 1'b1);
		`CHK("w inv", 8'hEC, w_reg)
		rd(12'h214, 32'h00000013);
		wr(12'h3FC, 8'hFF);
		ex(14'h09FF, 1'b0, 1'b1);
		rd(12'h3FC, 32'h00000000);
		`CHK("zero", 1'b1, zero_flag)
		`CHK("w kept", 8'hEC, w_reg)
		$display("test invert done");
		// back to back decrements of one register
		wr(12'h224, 8'h02);
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr_word <= 14'h0389;
		@(posedge clk_sys);
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rd(12'h224, 32'h00000000);
		$display("test back to back done");
		// W access, disabled execution, unknown word, unmapped place
		wr(`WCD_WREG_OFS, 8'h5A);
		rd(`WCD_WREG_OFS, 32'h0000005A);
		wr(`WCD_CTRL_OFS, 8'h00);
		ex(14'h0064, 1'b0, 1'b0);
		ex(14'h0305, 1'b0, 1'b0);
		rd(12'h214, 32'h00000013);
		wr(`WCD_CTRL_OFS, 8'h01);
		rd(`WCD_CTRL_OFS, 32'h00000001);
		ex(14'h3FFF, 1'b0, 1'b0);
		rd(`WCD_STAT_OFS, 32'h0000000F);
		wr(12'h100, 8'hA5);
		rd(12'h100, 32'h00000000);
		$display("test control done");
		print_verdict();
	end
endmodule : tb

bind wcd_exec wcd_exec_chk u_chk (.clk_sys(clk_sys), .resetn(resetn),
	.instr_valid(instr_valid), .instr_word(instr_word), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .wdt_count_clear(wdt_count_clear), .wdt_presc_clear(wdt_presc_clear),
	.timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n),
	.zero_flag(zero_flag), .w_reg(w_reg), .exec_done(exec_done));

`default_nettype wire
